// ===== power_budget_pkg.sv
// ****************************************************************
// power budget and strap register constants
// ****************************************************************
package power_budget_pkg;

    // register port geometry
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    localparam int          BE_W            = DATA_W / 8;
    localparam int          VALUE_WORDS     = 8;
    localparam int          VALUE_IDX_W     = 3;
    localparam int          SEL_W           = 8;

    // byte offsets
    localparam logic [11:0] OFS_SELECT      = 12'h284;
    localparam logic [11:0] OFS_WINDOW      = 12'h288;
    localparam logic [11:0] OFS_CAPABILITY  = 12'h28c;
    localparam logic [11:0] OFS_VALUE_BASE  = 12'h300;
    localparam logic [11:0] OFS_VALUE_LAST  = 12'h31c;
    localparam logic [11:0] OFS_STATUS      = 12'h400;

    // word index inside the value array sits in address bits 4:2
    localparam int          VALUE_IDX_LSB   = 2;
    localparam int          VALUE_IDX_MSB   = 4;

    // highest selector value that maps onto a value word
    localparam logic [7:0]  SEL_LAST_INDEX  = 8'h07;

    // field positions
    localparam int          SEL_LSB         = 0;
    localparam int          SEL_MSB         = 7;
    localparam int          SA_BIT          = 0;
    localparam int          MODE_LSB        = 0;
    localparam int          MODE_MSB        = 2;
    localparam int          CCLK_DS_BIT     = 5;
    localparam int          CCLK_US_BIT     = 6;
    localparam int          SMB_SLOW_BIT    = 7;
    localparam int          REFCLK_BIT      = 8;
    localparam int          HALT_BIT        = 9;

    // values after reset
    localparam logic [7:0]  SEL_RESET       = 8'h00;
    localparam logic        SA_RESET        = 1'b0;
    localparam logic [31:0] WINDOW_RESET    = 32'h0000_0000;
    localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

    // operating mode encodings
    localparam logic [2:0]  MODE_NORMAL     = 3'h0;
    localparam logic [2:0]  MODE_EEPROM     = 3'h1;

    // cycles from an accepted read to reg_rvalid
    localparam int          READ_LATENCY    = 2;

    // source of the word answered in the second read stage
    typedef enum logic [2:0]
    {
        SRC_IDLE = 3'b001,
        SRC_REG  = 3'b010,
        SRC_MEM  = 3'b100
    } read_source_type;

endpackage

// ===== budget_value_mem.sv
`timescale 1ns/100ps

// ****************************************************************
// budget value word store
// ****************************************************************
// no reset on purpose: contents are sticky and undefined at power-up
module budget_value_mem
    import power_budget_pkg::*;
#(
    parameter int WIDTH  = DATA_W,
    parameter int DEPTH  = VALUE_WORDS,
    parameter int AW     = VALUE_IDX_W
)
(
    // clock
    input  wire logic                 clk_sys,
    // write port
    input  wire logic                 wr_en,
    input  wire logic [AW-1:0]        wr_addr,
    input  wire logic [WIDTH/8-1:0]   wr_be,
    input  wire logic [WIDTH-1:0]     wr_data,
    // read port
    input  wire logic [AW-1:0]        rd_addr,
    output logic      [WIDTH-1:0]     rd_data
);

    // one byte array per lane, so no two processes share a storage variable
    for (genvar lane = 0; lane < WIDTH / 8; lane++)
    begin : g_lane
        logic [7:0] lane_ff [DEPTH];
        logic [7:0] lane_q_ff;

        // lane write plus registered read, read-first on the same word
        always_ff @(posedge clk_sys)
        begin
            if (wr_en && wr_be[lane])
            begin
                lane_ff[wr_addr] <= wr_data[lane*8 +: 8];
            end
            lane_q_ff <= lane_ff[rd_addr];
        end

        assign rd_data[lane*8 +: 8] = lane_q_ff;
    end

endmodule

// ===== power_budget_and_strap_regs.sv
`timescale 1ns/100ps

module power_budget_and_strap_regs
    import power_budget_pkg::*;
#(
    parameter int DWIDTH = DATA_W
)
(
    // clock and resets
    input  wire logic                 clk_sys,
    input  wire logic                 resetn,
    input  wire logic                 hot_reset,
    // configuration register port
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [BE_W-1:0]      reg_be,
    input  wire logic [DWIDTH-1:0]    reg_wdata,
    output logic      [DWIDTH-1:0]    reg_rdata,
    output logic                      reg_rvalid,
    // unlock bits from switch control
    input  wire logic                 register_unlock,
    input  wire logic                 budget_value_unlock,
    // strap pins
    input  wire logic [2:0]           mode_strap,
    input  wire logic                 downstream_common_clock_strap,
    input  wire logic                 upstream_common_clock_strap,
    input  wire logic                 master_smbus_slow_strap,
    input  wire logic                 refclk_mode_strap,
    input  wire logic                 reset_halt_strap,
    // state seen by the rest of the switch
    output logic      [SEL_W-1:0]     budget_selector,
    output logic                      system_allocated_flag,
    output logic      [2:0]           operating_mode_field
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed
    {
        logic [SEL_W-1:0]   sel;
        logic               sa;
        logic [2:0]         mode;
        logic               cclk_ds;
        logic               cclk_us;
        logic               smb_slow;
        logic               refclk;
        logic               halt;
        read_source_type    rd_src;
        logic [DWIDTH-1:0]  rd_word;
        logic               rd_zero;
        logic [DWIDTH-1:0]  rdata;
        logic               rvalid;
    } regs_state_type;

    regs_state_type                 state_ff;
    regs_state_type                 nxt_state;

    logic                           mem_we;
    logic [VALUE_IDX_W-1:0]         mem_waddr;
    logic [VALUE_IDX_W-1:0]         mem_raddr;
    logic [DWIDTH-1:0]              mem_q;
    logic [DWIDTH-1:0]              status_word;
    logic [DWIDTH-1:0]              capability_word;
    logic [DWIDTH-1:0]              select_word;

    // ****************************************************************
    // decode helpers
    // ****************************************************************
    // shared by the read and the write decode
    function automatic logic is_value_addr(input logic [ADDR_W-1:0] addr);
        logic hit;
        hit = (addr >= OFS_VALUE_BASE) && (addr <= OFS_VALUE_LAST)
              && (addr[1:0] == 2'b00);
        return hit;
    endfunction

    function automatic logic [VALUE_IDX_W-1:0] value_index(input logic [ADDR_W-1:0] addr);
        return addr[VALUE_IDX_MSB:VALUE_IDX_LSB];
    endfunction

    // ****************************************************************
    // read words built from the current state
    // ****************************************************************
    // fields above bit 9 belong to neighbouring logic and read zero here
    always_comb
    begin
        status_word                           = ZERO_WORD;
        status_word[MODE_MSB:MODE_LSB]        = state_ff.mode;
        status_word[CCLK_DS_BIT]              = state_ff.cclk_ds;
        status_word[CCLK_US_BIT]              = state_ff.cclk_us;
        status_word[SMB_SLOW_BIT]             = state_ff.smb_slow;
        status_word[REFCLK_BIT]               = state_ff.refclk;
        status_word[HALT_BIT]                 = state_ff.halt;
        capability_word                       = ZERO_WORD;
        capability_word[SA_BIT]               = state_ff.sa;
        select_word                           = ZERO_WORD;
        select_word[SEL_MSB:SEL_LSB]          = state_ff.sel;
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    // reset is synchronous, so the strap capture lives here as well
    always_comb
    begin
        nxt_state  = state_ff;
        mem_we     = 1'b0;
        mem_waddr  = value_index(reg_addr);
        mem_raddr  = value_index(reg_addr);

        // second read stage: answer from register word or memory
        nxt_state.rvalid = 1'b0;
        case (state_ff.rd_src)
            SRC_REG:
            begin
                nxt_state.rdata  = state_ff.rd_word;
                nxt_state.rvalid = 1'b1;
            end
            SRC_MEM:
            begin
                // oob selector answers zero instead of a wrapped index
                nxt_state.rdata  = state_ff.rd_zero ? ZERO_WORD : mem_q;
                nxt_state.rvalid = 1'b1;
            end
            default:
            begin
                nxt_state.rdata  = state_ff.rdata;
            end
        endcase

        // first read stage: decode and start the memory read
        nxt_state.rd_src  = SRC_IDLE;
        nxt_state.rd_zero = 1'b0;
        nxt_state.rd_word = ZERO_WORD;
        if (reg_rd)
        begin
            if (reg_addr == OFS_WINDOW)
            begin
                nxt_state.rd_src  = SRC_MEM;
                mem_raddr         = state_ff.sel[VALUE_IDX_W-1:0];
                nxt_state.rd_zero = (state_ff.sel > SEL_LAST_INDEX);
            end
            else if (is_value_addr(reg_addr))
            begin
                nxt_state.rd_src  = SRC_MEM;
            end
            else if (reg_addr == OFS_SELECT)
            begin
                nxt_state.rd_src  = SRC_REG;
                nxt_state.rd_word = select_word;
            end
            else if (reg_addr == OFS_CAPABILITY)
            begin
                nxt_state.rd_src  = SRC_REG;
                nxt_state.rd_word = capability_word;
            end
            else if (reg_addr == OFS_STATUS)
            begin
                nxt_state.rd_src  = SRC_REG;
                nxt_state.rd_word = status_word;
            end
            else
            begin
                // unmapped offsets still answer, with zero
                nxt_state.rd_src  = SRC_REG;
                nxt_state.rd_word = ZERO_WORD;
            end
        end

        // writes, also the loader's preload path; window and status take none
        if (reg_wr)
        begin
            if (reg_addr == OFS_SELECT)
            begin
                if (reg_be[0])
                begin
                    nxt_state.sel = reg_wdata[SEL_MSB:SEL_LSB];
                end
            end
            else if (reg_addr == OFS_CAPABILITY)
            begin
                if (reg_be[0] && register_unlock)
                begin
                    nxt_state.sa = reg_wdata[SA_BIT];
                end
            end
            else if (is_value_addr(reg_addr))
            begin
                mem_we = budget_value_unlock;
            end
            else if (reg_addr == OFS_WINDOW)
            begin
                nxt_state.sel = state_ff.sel;
            end
        end

        // hot reset clears selector and flag only, straps and value words are left alone
        if (hot_reset)
        begin
            nxt_state.sel = SEL_RESET;
            nxt_state.sa  = SA_RESET;
        end

        // fundamental reset: defaults, straps follow the pins
        if (!resetn)
        begin
            nxt_state.sel      = SEL_RESET;
            nxt_state.sa       = SA_RESET;
            nxt_state.mode     = mode_strap;
            nxt_state.cclk_ds  = downstream_common_clock_strap;
            nxt_state.cclk_us  = upstream_common_clock_strap;
            nxt_state.smb_slow = master_smbus_slow_strap;
            nxt_state.refclk   = refclk_mode_strap;
            nxt_state.halt     = reset_halt_strap;
            nxt_state.rd_src   = SRC_IDLE;
            nxt_state.rd_word  = ZERO_WORD;
            nxt_state.rd_zero  = 1'b0;
            nxt_state.rdata    = WINDOW_RESET;
            nxt_state.rvalid   = 1'b0;
            mem_we             = 1'b0;
        end
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge clk_sys)
    begin
        state_ff <= nxt_state;
    end

    // ****************************************************************
    // value word store
    // ****************************************************************
    // kept outside the reset path so hot and fundamental resets keep it
    budget_value_mem
    #(
        .WIDTH   (DWIDTH),
        .DEPTH   (VALUE_WORDS),
        .AW      (VALUE_IDX_W)
    )
    u_value_mem
    (
        .clk_sys (clk_sys),
        .wr_en   (mem_we),
        .wr_addr (mem_waddr),
        .wr_be   (reg_be),
        .wr_data (reg_wdata),
        .rd_addr (mem_raddr),
        .rd_data (mem_q)
    );

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign reg_rdata             = state_ff.rdata;
    assign reg_rvalid            = state_ff.rvalid;
    assign budget_selector       = state_ff.sel;
    assign system_allocated_flag = state_ff.sa;
    assign operating_mode_field  = state_ff.mode;

endmodule

// ===== power_budget_and_strap_regs_props.sv
`timescale 1ns/100ps

// ************************************************
// register slice checker
// ************************************************
module power_budget_and_strap_regs_props
    import power_budget_pkg::*;
#(
    parameter int DWIDTH = DATA_W
)
(
    // clock and resets
    input logic                 clk_sys,
    input logic                 resetn,
    input logic                 hot_reset,
    // register port
    input logic                 reg_wr,
    input logic                 reg_rd,
    input logic [ADDR_W-1:0]    reg_addr,
    input logic [BE_W-1:0]      reg_be,
    input logic [DWIDTH-1:0]    reg_wdata,
    input logic [DWIDTH-1:0]    reg_rdata,
    input logic                 reg_rvalid,
    // unlock bits
    input logic                 register_unlock,
    input logic                 budget_value_unlock,
    // straps
    input logic [2:0]           mode_strap,
    input logic                 downstream_common_clock_strap,
    input logic                 upstream_common_clock_strap,
    input logic                 master_smbus_slow_strap,
    input logic                 refclk_mode_strap,
    input logic                 reset_halt_strap,
    // state outputs
    input logic [SEL_W-1:0]     budget_selector,
    input logic                 system_allocated_flag,
    input logic [2:0]           operating_mode_field
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    // plain copies so that $past sees whole signals
    wire [7:0] wr_byte = reg_wdata[7:0];
    wire       wr_bit0 = reg_wdata[0];

    // read taken at one address
    sequence rd_req(logic [11:0] a);
        reg_rd && reg_addr == a;
    endsequence

    // write taken at one address, not overridden by hot reset
    sequence wr_req(logic [11:0] a);
        reg_wr && reg_addr == a && !hot_reset;
    endsequence

    AST_RD_LATENCY: assert property (reg_rd |-> ##2 reg_rvalid)
        else $error("read not answered after two cycles");
    AST_NO_STRAY: assert property (reg_rvalid |-> $past(reg_rd, 2))
        else $error("read answer without a request");
    AST_WIN_HIGH_ZERO: assert property (rd_req(OFS_WINDOW) ##0
        budget_selector > SEL_LAST_INDEX |-> ##2 reg_rdata == ZERO_WORD)
        else $error("window not zero for high selector");
    AST_CAP_RSVD: assert property (rd_req(OFS_CAPABILITY) |-> ##2
        reg_rdata[DWIDTH-1:1] == '0) else $error("capability reserved bits set");
    AST_STS_FIELDS: assert property (rd_req(OFS_STATUS) |-> ##2
        reg_rdata[DWIDTH-1:10] == '0 && reg_rdata[4:3] == 2'h0
        && reg_rdata[2:0] == $past(operating_mode_field, 2))
        else $error("status word fields wrong");
    AST_SEL_WRITE: assert property (wr_req(OFS_SELECT) ##0 reg_be[0]
        |=> budget_selector == $past(wr_byte)) else $error("selector write lost");
    AST_SA_WRITE: assert property (wr_req(OFS_CAPABILITY) ##0
        (reg_be[0] && register_unlock) |=> system_allocated_flag == $past(wr_bit0))
        else $error("allocation flag write lost");
    AST_SA_LOCKED: assert property (!register_unlock && !hot_reset
        |=> $stable(system_allocated_flag)) else $error("locked flag changed");
    AST_HOT_CLEAR: assert property (hot_reset |=> budget_selector == SEL_RESET
        && system_allocated_flag == SA_RESET) else $error("hot reset did not clear");
    AST_MODE_CAPTURE: assert property (resetn && !$past(resetn)
        |-> operating_mode_field == $past(mode_strap)) else $error("mode not captured");
    AST_STRAP_FROZEN: assert property (resetn && $past(resetn)
        |-> $stable(operating_mode_field)) else $error("mode moved after reset");
endmodule

bind power_budget_and_strap_regs power_budget_and_strap_regs_props
    #(.DWIDTH(DWIDTH)) props_inst
(
    .clk_sys                       (clk_sys),
    .resetn                        (resetn),
    .hot_reset                     (hot_reset),
    .reg_wr                        (reg_wr),
    .reg_rd                        (reg_rd),
    .reg_addr                      (reg_addr),
    .reg_be                        (reg_be),
    .reg_wdata                     (reg_wdata),
    .reg_rdata                     (reg_rdata),
    .reg_rvalid                    (reg_rvalid),
    .register_unlock               (register_unlock),
    .budget_value_unlock           (budget_value_unlock),
    .mode_strap                    (mode_strap),
    .downstream_common_clock_strap (downstream_common_clock_strap),
    .upstream_common_clock_strap   (upstream_common_clock_strap),
    .master_smbus_slow_strap       (master_smbus_slow_strap),
    .refclk_mode_strap             (refclk_mode_strap),
    .reset_halt_strap              (reset_halt_strap),
    .budget_selector               (budget_selector),
    .system_allocated_flag         (system_allocated_flag),
    .operating_mode_field          (operating_mode_field)
);

// ===== power_budget_and_strap_regs_test.sv
`timescale 1ns/100ps

// ************************************************
// register slice testbench
// ************************************************
module power_budget_and_strap_regs_test
    import power_budget_pkg::*;
;
    localparam int DLY = 1;
    logic                clk_sys, resetn, hot_reset, reg_wr, reg_rd, reg_rvalid;
    logic [ADDR_W-1:0]   reg_addr;
    logic [BE_W-1:0]     reg_be;
    logic [DATA_W-1:0]   reg_wdata, reg_rdata;
    logic                register_unlock, budget_value_unlock;
    logic [2:0]          mode_strap, operating_mode_field;
    logic                downstream_common_clock_strap, upstream_common_clock_strap;
    logic                master_smbus_slow_strap, refclk_mode_strap, reset_halt_strap;
    logic [SEL_W-1:0]    budget_selector;
    logic                system_allocated_flag;
    logic [11:0]         va;
    int                  mismatches, samples_checked, i;

    power_budget_and_strap_regs power_budget_and_strap_regs_inst
    (
        .clk_sys                       (clk_sys),
        .resetn                        (resetn),
        .hot_reset                     (hot_reset),
        .reg_wr                        (reg_wr),
        .reg_rd                        (reg_rd),
        .reg_addr                      (reg_addr),
        .reg_be                        (reg_be),
        .reg_wdata                     (reg_wdata),
        .reg_rdata                     (reg_rdata),
        .reg_rvalid                    (reg_rvalid),
        .register_unlock               (register_unlock),
        .budget_value_unlock           (budget_value_unlock),
        .mode_strap                    (mode_strap),
        .downstream_common_clock_strap (downstream_common_clock_strap),
        .upstream_common_clock_strap   (upstream_common_clock_strap),
        .master_smbus_slow_strap       (master_smbus_slow_strap),
        .refclk_mode_strap             (refclk_mode_strap),
        .reset_halt_strap              (reset_halt_strap),
        .budget_selector               (budget_selector),
        .system_allocated_flag         (system_allocated_flag),
        .operating_mode_field          (operating_mode_field)
    );

    // 20 MHz system clock
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // ************************************************
    // helpers
    // ************************************************
    task summarize;
        if (mismatches == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // direct look at a state output pin, unknown bits count as wrong
    task chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: state pin got %h expected %h", $time, got, exp);
        end
    endtask

    function automatic logic [31:0] sts(input logic [2:0] m, input logic [4:0] s);
        return {22'h0, s, 2'b00, m};
    endfunction

    // distinct pattern per word so a wrong index shows
    function automatic logic [31:0] val_word(input int k);
        return {8'hc3, 8'(k), 8'h5a ^ 8'(k), 8'(k * 17)};
    endfunction

    task set_straps(input logic [2:0] m, input logic [4:0] s);
        mode_strap = m;
        {reset_halt_strap, refclk_mode_strap, master_smbus_slow_strap,
         upstream_common_clock_strap, downstream_common_clock_strap} = s;
    endtask

    // pins flip right at release, so a late capture is caught
    task do_reset(input logic [2:0] m, input logic [4:0] s);
        resetn = 1'b0;
        set_straps(m, s);
        repeat (2) @(posedge clk_sys);
        #DLY resetn = 1'b1;
        set_straps(~m, ~s);
    endtask

    // idle cycle after each write keeps strobe edges apart
    task wr(input logic [11:0] a, input logic [3:0] be, input logic [31:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_be = be;
        reg_wdata = d;
        @(posedge clk_sys);
        #DLY reg_wr = 1'b0;
        @(posedge clk_sys);
        #DLY;
    endtask

    task rd(input logic [11:0] a, input logic [31:0] exp);
        int n;
        reg_rd = 1'b1;
        reg_addr = a;
        @(posedge clk_sys);
        #DLY reg_rd = 1'b0;
        for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++)
        begin
            @(posedge clk_sys);
            #DLY;
        end
        if (reg_rvalid !== 1'b1)
        begin
            mismatches++;
            $display("ERROR %0t: no read answer at %h", $time, a);
            summarize();
        end
        else
        begin
            samples_checked++;
            if (reg_rdata !== exp)
            begin
                mismatches++;
                $display("ERROR %0t: at %h got %h expected %h", $time, a, reg_rdata, exp);
            end
            @(posedge clk_sys);
            #DLY;
        end
    endtask

    // ************************************************
    // main sequence
    // ************************************************
    initial
    begin
        mismatches = 0;
        samples_checked = 0;
        {hot_reset, reg_wr, reg_rd, register_unlock, budget_value_unlock} = 5'h00;
        reg_addr = '0;
        reg_be = '0;
        reg_wdata = '0;
        do_reset(MODE_EEPROM, 5'h15);
        rd(OFS_STATUS, sts(MODE_EEPROM, 5'h15));
        chk(32'(operating_mode_field), 32'(MODE_EEPROM));
        rd(OFS_SELECT, 32'h0);
        rd(OFS_CAPABILITY, 32'h0);
        // flag locked, then unlocked
        wr(OFS_CAPABILITY, 4'hf, 32'hffff_ffff);
        rd(OFS_CAPABILITY, 32'h0);
        register_unlock = 1'b1;
        wr(OFS_CAPABILITY, 4'hf, 32'hffff_ffff);
        rd(OFS_CAPABILITY, 32'h1);
        chk(32'(system_allocated_flag), 32'h1);
        wr(OFS_STATUS, 4'hf, 32'hffff_ffff);
        rd(OFS_STATUS, sts(MODE_EEPROM, 5'h15));
        // fill words, then locked overwrite must be discarded
        budget_value_unlock = 1'b1;
        for (i = 0; i < 8; i++)
            wr(OFS_VALUE_BASE + 12'(4 * i), 4'hf, val_word(i));
        budget_value_unlock = 1'b0;
        for (i = 0; i < 8; i++)
        begin
            va = OFS_VALUE_BASE + 12'(4 * i);
            wr(va, 4'hf, ~val_word(i));
            rd(va, val_word(i));
            wr(OFS_SELECT, 4'h1, 32'(i));
            rd(OFS_WINDOW, val_word(i));
        end
        wr(OFS_WINDOW, 4'hf, 32'h0);
        rd(OFS_WINDOW, val_word(7));
        // boundary and top selector values
        wr(OFS_SELECT, 4'h1, 32'h8);
        rd(OFS_WINDOW, 32'h0);
        wr(OFS_SELECT, 4'h1, 32'hff);
        rd(OFS_SELECT, 32'hff);
        chk(32'(budget_selector), 32'hff);
        rd(OFS_WINDOW, 32'h0);
        wr(OFS_SELECT, 4'he, 32'h3);
        rd(OFS_SELECT, 32'hff);
        // single byte lane update
        budget_value_unlock = 1'b1;
        wr(OFS_VALUE_BASE + 12'h8, 4'h2, 32'h0000_5a00);
        rd(OFS_VALUE_BASE + 12'h8, (val_word(2) & 32'hffff_00ff) | 32'h0000_5a00);
        rd(12'h301, 32'h0);
        rd(12'h500, 32'h0);
        // hot reset clears selector and flag only
        hot_reset = 1'b1;
        @(posedge clk_sys);
        #DLY hot_reset = 1'b0;
        chk(32'(budget_selector), 32'h0);
        chk(32'(system_allocated_flag), 32'h0);
        rd(OFS_SELECT, 32'h0);
        rd(OFS_CAPABILITY, 32'h0);
        rd(OFS_VALUE_BASE + 12'h4, val_word(1));
        // second fundamental reset with the other mode code
        do_reset(MODE_NORMAL, 5'h0a);
        rd(OFS_STATUS, sts(MODE_NORMAL, 5'h0a));
        chk(32'(operating_mode_field), 32'(MODE_NORMAL));
        rd(OFS_VALUE_BASE + 12'hc, val_word(3));
        summarize();
    end
endmodule
